//--- hw/pdb_defs.vh
`ifndef PDB_DEFS_VH
`define PDB_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PDB_OFS_OVR_MASK0     8'h60
`define PDB_OFS_OVR_MASK1     8'h62
`define PDB_OFS_OVR_MASK2     8'h64
`define PDB_OFS_OVR_MASK3     8'h66
`define PDB_OFS_OVR_DIR       8'h6a
`define PDB_OFS_OVR_DIR_HI    8'h6b
`define PDB_OFS_CNT_TEN_MILLI 8'h6c
`define PDB_OFS_CNT_ONE_MILLI 8'h6d
`define PDB_OFS_CNT_ONE_MICRO 8'h6e
`define PDB_OFS_STATUS        8'h6f
`define PDB_OFS_SELECT        8'h70

// ----------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------
`define PDB_RST_CNT           8'h0a
`define PDB_RST_OVR_DIR       16'h0000
`define PDB_RST_OVR_MASK      16'h0000
`define PDB_RST_SELECT        32'h00000000
`define PDB_STS_ACT_BIT       0
`define PDB_SEL_OFF           2'b00
`define PDB_SEL_MICRO         2'b01
`define PDB_SEL_MILLI         2'b10
`define PDB_SEL_TEN_MILLI     2'b11

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PDB_CLK_PERIOD_NS     40
`define PDB_MICRO_NS          1000
`define PDB_MICRO_CYC         (`PDB_MICRO_NS / `PDB_CLK_PERIOD_NS)
`define PDB_MILLI_US          1000
`define PDB_TEN_MILLI_MS      10
// last prescaler states, sized to their counters
`define PDB_MICRO_LAST        5'h18
`define PDB_MILLI_LAST        10'h3e7
`define PDB_TEN_MILLI_LAST    4'h9

`endif

//--- hw/pdb_debounce.v
`include "pdb_defs.vh"
`default_nettype none

module pdb_debounce (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  csr_addr,
  input  wire [7:0]  csr_wdata,
  input  wire        csr_we,
  input  wire        csr_re,
  output reg  [7:0]  csr_rdata,
  input  wire [15:0] pin_raw,
  output reg  [15:0] pin_filtered,
  input  wire [3:0]  ovr_triggered,
  output reg  [15:0] ovr_dir_apply,
  output reg  [15:0] ovr_dir_value
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // picks the timebase tick named by a pin's select field
  function sel_tick;
    input [1:0] sel;
    input       t_us;
    input       t_ms;
    input       t_10ms;
    begin
      case (sel)
        `PDB_SEL_MICRO:     sel_tick = t_us;
        `PDB_SEL_MILLI:     sel_tick = t_ms;
        `PDB_SEL_TEN_MILLI: sel_tick = t_10ms;
        default:            sel_tick = 1'b0;
      endcase
    end
  endfunction

  // picks the count register named by a pin's select field
  function [7:0] sel_count;
    input [1:0] sel;
    input [7:0] c_us;
    input [7:0] c_ms;
    input [7:0] c_10ms;
    begin
      case (sel)
        `PDB_SEL_MICRO:     sel_count = c_us;
        `PDB_SEL_MILLI:     sel_count = c_ms;
        `PDB_SEL_TEN_MILLI: sel_count = c_10ms;
        default:            sel_count = 8'h00;
      endcase
    end
  endfunction

  // true when addr names byte b of override mask m
  function mask_byte_hit;
    input [7:0] addr;
    input [1:0] m;
    input       b;
    begin
      mask_byte_hit = (addr == `PDB_OFS_OVR_MASK0 + {5'h00, m, b});
    end
  endfunction

  // true when addr names byte b of the select register
  function sel_byte_hit;
    input [7:0] addr;
    input [1:0] b;
    begin
      sel_byte_hit = (addr == `PDB_OFS_SELECT + {6'h00, b});
    end
  endfunction

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  reg  [15:0] ovr_dir_q;
  reg  [15:0] ovr_mask_q [0:3];
  reg  [7:0]  cnt_10ms_q;
  reg  [7:0]  cnt_1ms_q;
  reg  [7:0]  cnt_1us_q;
  reg  [31:0] select_q;
  wire [15:0] pend;
  wire        any_pend = |pend;
  wire [15:0] filt_d;
  integer     k;
  integer     m;

  // byte-wide writes; multi-byte registers are little endian
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ovr_dir_q  <= `PDB_RST_OVR_DIR;
      cnt_10ms_q <= `PDB_RST_CNT;
      cnt_1ms_q  <= `PDB_RST_CNT;
      cnt_1us_q  <= `PDB_RST_CNT;
      select_q   <= `PDB_RST_SELECT;
      for (k = 0; k < 4; k = k + 1)
        ovr_mask_q[k] <= `PDB_RST_OVR_MASK;
    end
    else if (csr_we)
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        if (mask_byte_hit(csr_addr, k[1:0], 1'b0))
          ovr_mask_q[k][7:0] <= csr_wdata;
        if (mask_byte_hit(csr_addr, k[1:0], 1'b1))
          ovr_mask_q[k][15:8] <= csr_wdata;
      end
      for (k = 0; k < 4; k = k + 1)
        if (sel_byte_hit(csr_addr, k[1:0]))
          select_q[8 * k +: 8] <= csr_wdata;
      case (csr_addr)
        `PDB_OFS_OVR_DIR:       ovr_dir_q[7:0]  <= csr_wdata;
        `PDB_OFS_OVR_DIR_HI:    ovr_dir_q[15:8] <= csr_wdata;
        `PDB_OFS_CNT_TEN_MILLI: cnt_10ms_q      <= csr_wdata;
        `PDB_OFS_CNT_ONE_MILLI: cnt_1ms_q       <= csr_wdata;
        `PDB_OFS_CNT_ONE_MICRO: cnt_1us_q       <= csr_wdata;
        default:                ;
      endcase
    end
  end

  // read data is registered: valid the cycle after csr_re
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      csr_rdata <= 8'h00;
    else if (csr_re)
    begin
      // a read in the cycle of a write to the same byte sees the old value
      csr_rdata <= 8'h00;  // unmapped offsets read zero
      for (m = 0; m < 4; m = m + 1)
      begin
        if (mask_byte_hit(csr_addr, m[1:0], 1'b0))
          csr_rdata <= ovr_mask_q[m][7:0];
        if (mask_byte_hit(csr_addr, m[1:0], 1'b1))
          csr_rdata <= ovr_mask_q[m][15:8];
        if (sel_byte_hit(csr_addr, m[1:0]))
          csr_rdata <= select_q[8 * m +: 8];
      end
      case (csr_addr)
        `PDB_OFS_OVR_DIR:       csr_rdata <= ovr_dir_q[7:0];
        `PDB_OFS_OVR_DIR_HI:    csr_rdata <= ovr_dir_q[15:8];
        `PDB_OFS_CNT_TEN_MILLI: csr_rdata <= cnt_10ms_q;
        `PDB_OFS_CNT_ONE_MILLI: csr_rdata <= cnt_1ms_q;
        `PDB_OFS_CNT_ONE_MICRO: csr_rdata <= cnt_1us_q;
        `PDB_OFS_STATUS:        csr_rdata <= {7'h00, any_pend};
        default:                ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // shared timebases
  // --------------------------------------------------------------------
  // one free-running chain; pins share it, so the first unit of a
  // debounce is partial and the period lands on count or count-1
  reg [4:0] pre_us_q;
  reg [9:0] pre_ms_q;
  reg [3:0] pre_10ms_q;
  reg       tick_us_q;
  reg       tick_ms_q;
  reg       tick_10ms_q;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_us_q    <= 5'h00;
      pre_ms_q    <= 10'h000;
      pre_10ms_q  <= 4'h0;
      tick_us_q   <= 1'b0;
      tick_ms_q   <= 1'b0;
      tick_10ms_q <= 1'b0;
    end
    else
    begin
      tick_us_q   <= 1'b0;
      tick_ms_q   <= 1'b0;
      tick_10ms_q <= 1'b0;
      // only the microsecond last state assumes the 40 ns clock; retune it with it
      if (pre_us_q == `PDB_MICRO_LAST)
      begin
        pre_us_q  <= 5'h00;
        tick_us_q <= 1'b1;
        if (pre_ms_q == `PDB_MILLI_LAST)
        begin
          pre_ms_q  <= 10'h000;
          tick_ms_q <= 1'b1;
          if (pre_10ms_q == `PDB_TEN_MILLI_LAST)
          begin
            pre_10ms_q  <= 4'h0;
            tick_10ms_q <= 1'b1;
          end
          else
            pre_10ms_q <= pre_10ms_q + 4'h1;
        end
        else
          pre_ms_q <= pre_ms_q + 10'h001;
      end
      else
        pre_us_q <= pre_us_q + 5'h01;
    end
  end

  // --------------------------------------------------------------------
  // per-pin debounce
  // --------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 16; p = p + 1)
    begin : g_pin
      reg  [7:0] units_q;
      reg        pend_q;
      wire [1:0] sel    = select_q[2 * p +: 2];
      wire       tick   = sel_tick(sel, tick_us_q, tick_ms_q, tick_10ms_q);
      wire [7:0] limit  = sel_count(sel, cnt_1us_q, cnt_1ms_q, cnt_10ms_q);
      wire       differ = (pin_raw[p] != pin_filtered[p]);
      // a count of zero takes the new level at once
      wire       done   = (limit == 8'h00) || (tick && (units_q + 8'h01 >= limit));
      assign pend[p] = pend_q;
      // off follows the pin; otherwise the level moves only when done
      assign filt_d[p] = (sel == `PDB_SEL_OFF || (differ && done)) ? pin_raw[p] : pin_filtered[p];

      // a new level is taken only once limit ticks have come while it stood;
      // a glitch that returns earlier clears the pending state
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          units_q <= 8'h00;
          pend_q  <= 1'b0;
        end
        else if (sel == `PDB_SEL_OFF)
        begin
          units_q <= 8'h00;
          pend_q  <= 1'b0;
        end
        else if (!differ)
        begin
          units_q <= 8'h00;
          pend_q  <= 1'b0;
        end
        else if (done)
        begin
          units_q <= 8'h00;
          pend_q  <= 1'b0;
        end
        else
        begin
          pend_q <= 1'b1;
          if (tick)
            units_q <= units_q + 8'h01;
        end
      end
    end
  endgenerate

  // all pins registered in one process so the output has one driver
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      pin_filtered <= 16'h0000;
    else
      pin_filtered <= filt_d;
  end

  // --------------------------------------------------------------------
  // override direction
  // --------------------------------------------------------------------
  // a pin is claimed if any triggered override lists it in its mask
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ovr_dir_apply <= 16'h0000;
      ovr_dir_value <= 16'h0000;
    end
    else
    begin
      ovr_dir_apply <= ({16{ovr_triggered[0]}} & ovr_mask_q[0])
                     | ({16{ovr_triggered[1]}} & ovr_mask_q[1])
                     | ({16{ovr_triggered[2]}} & ovr_mask_q[2])
                     | ({16{ovr_triggered[3]}} & ovr_mask_q[3]);
      ovr_dir_value <= ovr_dir_q;
    end
  end

endmodule // pdb_debounce

`default_nettype wire

//--- dv/pdb_debounce_assertions.sv
`default_nettype none
module pdb_debounce_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  csr_addr,
  input wire logic [7:0]  csr_wdata,
  input wire logic        csr_we,
  input wire logic        csr_re,
  input wire logic [7:0]  csr_rdata,
  input wire logic [15:0] pin_raw,
  input wire logic [15:0] pin_filtered,
  input wire logic [3:0]  ovr_triggered,
  input wire logic [15:0] ovr_dir_apply,
  input wire logic [15:0] ovr_dir_value
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // register port
  // ----------------------------------------
  rd_hold_a: assert property (!csr_re |=> $stable(csr_rdata)) else $error("rdata moved");
  sts_rsvd_a: assert property (csr_re && csr_addr == 8'h6f |=> csr_rdata[7:1] == 7'h00) else $error("sts bits");
  cnt_back_a: assert property (csr_we && csr_addr inside {8'h6c, 8'h6d, 8'h6e} ##1 !csr_we ##1
    (csr_re && csr_addr == $past(csr_addr, 2)) |=> csr_rdata == $past(csr_wdata, 3)) else $error("count");
  sel_back_a: assert property (csr_we && csr_addr inside {[8'h70:8'h73]} ##1 !csr_we ##1
    (csr_re && csr_addr == $past(csr_addr, 2)) |=> csr_rdata == $past(csr_wdata, 3)) else $error("select");
  // ----------------------------------------
  // pins and override
  // ----------------------------------------
  // filtered bits may only move to the level the pin showed
  filt_src_a: assert property ($changed(pin_filtered) |->
    ((pin_filtered ^ $past(pin_filtered)) & (pin_filtered ^ $past(pin_raw))) == 16'h0000) else $error("filt");
  sts_idle_a: assert property ((pin_raw == pin_filtered) [*3] ##0 (csr_re && csr_addr == 8'h6f)
    |=> csr_rdata == 8'h00) else $error("pending stuck");
  dir_chg_a: assert property ($changed(ovr_dir_value) |-> $past(csr_we) || $past(csr_we, 2)) else $error("dir");
  apply_idle_a: assert property ((ovr_triggered == 4'h0) [*2] |=> ovr_dir_apply == 16'h0000) else $error("apply");
endmodule // pdb_debounce_assertions
bind pdb_debounce pdb_debounce_assertions u_chk (.clk(clk), .rst(rst), .csr_addr(csr_addr),
  .csr_wdata(csr_wdata), .csr_we(csr_we), .csr_re(csr_re), .csr_rdata(csr_rdata), .pin_raw(pin_raw),
  .pin_filtered(pin_filtered), .ovr_triggered(ovr_triggered), .ovr_dir_apply(ovr_dir_apply),
  .ovr_dir_value(ovr_dir_value));
`default_nettype wire

//--- dv/pdb_pin_model.sv
`default_nettype none
// ----------------------------------------
// external pin levels
// ----------------------------------------
module pdb_pin_model (
  input  wire logic        clk,
  output var  logic [15:0] pin_raw
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin_raw = 16'h0000;
  // change just after an edge, as a synchronised source would
  task automatic drive(input logic [15:0] lvl);
    @(posedge clk);
    pin_raw <= lvl;
  endtask
endmodule // pdb_pin_model
`default_nettype wire

//--- dv/pdb_debounce_bench.sv
`default_nettype none
module pdb_debounce_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  csr_addr = 8'h00;
  logic [7:0]  csr_wdata = 8'h00;
  logic        csr_we = 1'b0;
  logic        csr_re = 1'b0;
  logic [3:0]  ovr_triggered = 4'h0;
  logic [7:0]  rdv;
  wire  [7:0]  csr_rdata;
  wire  [15:0] pin_raw, pin_filtered, ovr_dir_apply, ovr_dir_value;
  int          errors = 0;
  int          comparisons = 0;
  always #20 clk = ~clk;
  pdb_pin_model pins (.clk(clk), .pin_raw(pin_raw));
  pdb_debounce uut (.clk(clk), .rst(rst), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_we(csr_we),
    .csr_re(csr_re), .csr_rdata(csr_rdata), .pin_raw(pin_raw), .pin_filtered(pin_filtered),
    .ovr_triggered(ovr_triggered), .ovr_dir_apply(ovr_dir_apply), .ovr_dir_value(ovr_dir_value));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    csr_addr <= a;
    csr_wdata <= d;
    csr_we <= 1'b1;
    @(posedge clk);
    csr_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    csr_addr <= a;
    csr_re <= 1'b1;
    @(posedge clk);
    csr_re <= 1'b0;
    #1 rdv = csr_rdata;
  endtask
  // bounded wait for one filtered bit to rise
  task automatic wait_pin(input int idx, input int lim);
    for (int n = 0; pin_filtered[idx] !== 1'b1; n++)
    begin
      if (n >= lim)
      begin
        errors++;
        tally_and_finish();
      end
      @(posedge clk);
      #1;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [7:0] adr [10] = '{8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h73, 8'h60, 8'h10};
    logic [7:0] exp [10] = '{8'h00, 8'h00, 8'h0a, 8'h0a, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++)
    begin
      rd(adr[i]);
      chk(rdv, exp[i]);
    end
  endtask
  task automatic t_regs;
    logic [7:0] adr [9] = '{8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h70, 8'h71, 8'h72, 8'h73};
    for (int i = 0; i < 9; i++)
    begin
      wr(adr[i], 8'hff - 8'(i));
      rd(adr[i]);
      chk(rdv, 8'hff - 8'(i));
    end
    wr(8'h6f, 8'hff);
    rd(8'h6f);
    chk(rdv, 8'h00);
    chk(ovr_dir_value, 16'hfeff);
  endtask
  // pin 3 on the microsecond base, count 4: 75 to 100 cycles
  task automatic t_micro;
    wr(8'h70, 8'h40);
    wr(8'h6e, 8'h04);
    pins.drive(16'h0008);
    repeat (48) @(posedge clk);
    rd(8'h6f);
    chk(rdv, 8'h01);
    pins.drive(16'h0000);
    repeat (60) @(posedge clk);
    #1 chk(pin_filtered, 16'h0000);
    rd(8'h6f);
    chk(rdv, 8'h00);
    pins.drive(16'h0008);
    repeat (70) @(posedge clk);
    #1 chk(pin_filtered, 16'h0000);
    wait_pin(3, 40);
  endtask
  // pin0 milli, pin1 ten milli, pin2 off
  task automatic t_modes;
    wr(8'h70, 8'h4e);
    wr(8'h6d, 8'h01);
    wr(8'h6c, 8'h00);
    pins.drive(16'h000f);
    @(posedge clk);
    #1 chk(pin_filtered[2], 1'b1);
    wait_pin(1, 4);
    wait_pin(0, 25010);
  endtask
  // overlapping masks: pins 4..7 claimed by overrides 0 and 1
  task automatic t_override;
    logic [3:0]  trg [6] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h4, 4'h8};
    logic [15:0] app [6] = '{16'h00f0, 16'h0ff0, 16'h0ff0, 16'h0000, 16'h0000, 16'h8001};
    wr(8'h60, 8'hf0);
    wr(8'h62, 8'hf0);
    wr(8'h63, 8'h0f);
    wr(8'h66, 8'h01);
    wr(8'h67, 8'h80);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      ovr_triggered <= trg[i];
      repeat (2) @(posedge clk);
      #1 chk(ovr_dir_apply, app[i]);
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_micro();
    t_modes();
    t_override();
    tally_and_finish();
  end
endmodule // pdb_debounce_bench
`default_nettype wire
